// [src/mpsq_pkg.sv]
package mpsq_pkg;
  // Table of one electrical revolution at the finest resolution: 32 positions.
  localparam int unsigned POS_W = 5;
  localparam logic [4:0] POS_INIT = 5'h00;
  // Magnitude in percent of full scale; sign carried separately.
  localparam int unsigned MAG_W = 8;
  localparam logic [7:0] MAG_FULL = 8'h64;
  localparam logic [7:0] MAG_ZERO = 8'h00;
  // Chop off time in falling edges of the chop oscillator.
  localparam logic [2:0] OFF_CYCLES = 3'h4;
  // Position increment per step, per mode (table length 32 / increment).
  localparam logic [4:0] INC_FULL = 5'h08;
  localparam logic [4:0] INC_HALF = 5'h04;
  localparam logic [4:0] INC_QUARTER = 5'h02;
  localparam logic [4:0] INC_EIGHTH = 5'h01;
  // Full step sits 45 degrees before the initial A-axis point.
  localparam logic [4:0] FULL_OFFSET = 5'h1C;

  typedef enum logic [1:0] {
    MPSQ_MODE_FULL = 2'h0,
    MPSQ_MODE_HALF = 2'h1,
    MPSQ_MODE_QUARTER = 2'h2,
    MPSQ_MODE_EIGHTH = 2'h3
  } mpsq_mode_t;

  typedef enum logic [1:0] {
    MPSQ_CHARGE = 2'b01,
    MPSQ_CHOP_OFF = 2'b10
  } mpsq_chop_t;

  typedef struct packed {
    logic neg;
    logic [7:0] mag;
  } mpsq_cur_t;

  typedef struct packed {
    logic out_p;
    logic out_n;
    logic oe_n;
  } mpsq_bridge_t;
endpackage

// [src/mpsq_chopper.sv]
`timescale 1ns/1ps
module mpsq_chopper (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic chop_tick, // One-cycle pulse per oscillator falling edge
  input wire logic sense_hit, // Sense voltage at or above reference
  output logic power_on // Bridge conducts when high
);
  mpsq_pkg::mpsq_chop_t state;
  logic [2:0] off_cnt;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= mpsq_pkg::MPSQ_CHARGE;
      off_cnt <= 3'h0;
    end else begin
      case (state)
        mpsq_pkg::MPSQ_CHARGE: begin
          if (sense_hit) begin
            state <= mpsq_pkg::MPSQ_CHOP_OFF;
            off_cnt <= 3'h0;
          end
        end
        mpsq_pkg::MPSQ_CHOP_OFF: begin
          if (chop_tick) begin
            if (off_cnt == mpsq_pkg::OFF_CYCLES - 3'h1) begin
              state <= mpsq_pkg::MPSQ_CHARGE;
              off_cnt <= 3'h0;
            end else begin
              off_cnt <= off_cnt + 3'h1;
            end
          end
        end
        default: begin
          state <= mpsq_pkg::MPSQ_CHARGE;
        end
      endcase
    end
  end

  // Re-checked on entry to charge: a still-high sense drops straight back off
  assign power_on = (state == mpsq_pkg::MPSQ_CHARGE) && !sense_hit;
endmodule

// [src/mpsq_sequencer.sv]
`timescale 1ns/1ps
// Function
// - Output enable low floats bridge only
// - Position keeps stepping while outputs disabled
// - Re-enable resumes at current counter position
// - Reset returns home, monitor pulled low
// - Home position commands A at +100%
// - Release with clock low waits rising edge
// - Release with clock high advances immediately
// - Comparator trip switches bridge to off
// - Off time is four oscillator falling edges
// - Full step spans 90 degrees of table
// - Two select inputs choose excitation mode
// - Direction low forward, high reverse
// - Standby floats outputs overriding everything
// - Home is A+100/B-100 full, else A100/B0
module mpsq_sequencer (
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic rst_n, // Synchronous system reset, active low
  input wire logic step_clock, // Step clock from host
  input wire logic rotation_dir, // Low forward, high reverse
  input wire logic step_mode_sel0, // Mode select bit 0
  input wire logic step_mode_sel1, // Mode select bit 1
  input wire logic reset_n, // Sequencer reset input, active low
  input wire logic enable_n_low, // Output enable input, high drives
  input wire logic standby_n, // Standby input, active low
  input wire logic chop_oscillator, // Internal chop oscillator clock
  input wire logic sense_a_hit, // A sense voltage reached reference
  input wire logic sense_b_hit, // B sense voltage reached reference
  output mpsq_pkg::mpsq_cur_t cur_a, // A-phase current command
  output mpsq_pkg::mpsq_cur_t cur_b, // B-phase current command
  output mpsq_pkg::mpsq_bridge_t phase_a, // A bridge drive and float
  output mpsq_pkg::mpsq_bridge_t phase_b, // B bridge drive and float
  output logic home_position_flag_n_o, // Monitor open-drain data, always 0
  output logic home_position_flag_n_oe_n // Monitor enable, low pulls low
);
  logic [4:0] pos;
  logic [4:0] next_pos;
  logic [4:0] inc;
  logic step_clock_q;
  logic chop_q;
  logic chop_fall;
  logic rst_q;
  logic full_mode;
  logic a_on;
  logic b_on;
  mpsq_pkg::mpsq_mode_t mode;
  mpsq_pkg::mpsq_cur_t next_a;
  mpsq_pkg::mpsq_cur_t next_b;

  // Quarter-wave magnitudes in percent at 11.25 degree spacing
  function automatic logic [7:0] quarter_mag(input logic [3:0] idx);
    logic [7:0] m;
    m = 8'h00;
    case (idx)
      4'h0: m = 8'h64;
      4'h1: m = 8'h62;
      4'h2: m = 8'h5C;
      4'h3: m = 8'h53;
      4'h4: m = 8'h47;
      4'h5: m = 8'h38;
      4'h6: m = 8'h26;
      4'h7: m = 8'h14;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Cosine of table angle: 32 positions, 8 per 90 degree step
  function automatic mpsq_pkg::mpsq_cur_t cos_at(input logic [4:0] p);
    mpsq_pkg::mpsq_cur_t c;
    logic [3:0] k;
    k = 4'h0;
    c.neg = 1'b0;
    c.mag = 8'h00;
    case (p[4:3])
      2'h0: k = {1'b0, p[2:0]};
      2'h1: k = 4'h8 - {1'b0, p[2:0]};
      2'h2: k = {1'b0, p[2:0]};
      default: k = 4'h8 - {1'b0, p[2:0]};
    endcase
    c.mag = quarter_mag(k);
    c.neg = (p[4:3] == 2'h1 || p[4:3] == 2'h2) && (c.mag != 8'h00);
    return c;
  endfunction

  assign mode = mpsq_pkg::mpsq_mode_t'({step_mode_sel1, step_mode_sel0});
  assign full_mode = (mode == mpsq_pkg::MPSQ_MODE_FULL);

  always_comb begin
    case (mode)
      mpsq_pkg::MPSQ_MODE_FULL: inc = mpsq_pkg::INC_FULL;
      mpsq_pkg::MPSQ_MODE_HALF: inc = mpsq_pkg::INC_HALF;
      mpsq_pkg::MPSQ_MODE_QUARTER: inc = mpsq_pkg::INC_QUARTER;
      default: inc = mpsq_pkg::INC_EIGHTH;
    endcase
  end

  // Step on rising edge, or at once when reset lifts with clock already high
  always_comb begin
    next_pos = pos;
    if (!standby_n || !reset_n) begin
      next_pos = mpsq_pkg::POS_INIT;
    end else if ((step_clock && !step_clock_q) || (step_clock && !rst_q)) begin
      if (rotation_dir) begin
        next_pos = pos - inc;
      end else begin
        next_pos = pos + inc;
      end
    end
  end

  // Enable is ignored here so the count carries on while floated
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pos <= mpsq_pkg::POS_INIT;
    end else begin
      pos <= next_pos;
    end
  end

  // Clock level and release history, so a clock held high over release steps once
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      step_clock_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      step_clock_q <= step_clock;
      rst_q <= reset_n && standby_n;
    end
  end

  // Full step offsets by 45 degrees so both phases carry current
  always_comb begin
    logic [4:0] ang_a;
    logic [4:0] ang_b;
    ang_a = 5'h00;
    ang_b = 5'h00;
    if (full_mode) begin
      ang_a = next_pos + mpsq_pkg::FULL_OFFSET;
    end else begin
      ang_a = next_pos;
    end
    ang_b = ang_a - 5'h08;
    next_a = cos_at(ang_a);
    next_b = cos_at(ang_b);
    if (full_mode) begin
      next_a.mag = mpsq_pkg::MAG_FULL;
      next_b.mag = mpsq_pkg::MAG_FULL;
    end
  end

  // Home currents depend on the mode, so reset follows the selects
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_a <= '{neg: 1'b0, mag: mpsq_pkg::MAG_FULL};
      if (full_mode) begin
        cur_b <= '{neg: 1'b1, mag: mpsq_pkg::MAG_FULL};
      end else begin
        cur_b <= '{neg: 1'b0, mag: mpsq_pkg::MAG_ZERO};
      end
    end else begin
      cur_a <= next_a;
      cur_b <= next_b;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chop_q <= 1'b0;
    end else begin
      chop_q <= chop_oscillator;
    end
  end

  // One shared detector keeps both off-timers in step
  assign chop_fall = chop_q && !chop_oscillator;

  mpsq_chopper u_chop_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .chop_tick(chop_fall),
    .sense_hit(sense_a_hit),
    .power_on(a_on)
  );

  mpsq_chopper u_chop_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .chop_tick(chop_fall),
    .sense_hit(sense_b_hit),
    .power_on(b_on)
  );

  // Drive follows the live position whenever enable returns
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_a <= '{out_p: 1'b0, out_n: 1'b0, oe_n: 1'b1};
      phase_b <= '{out_p: 1'b0, out_n: 1'b0, oe_n: 1'b1};
    end else begin
      phase_a.out_p <= a_on && !next_a.neg && (next_a.mag != 8'h00);
      phase_a.out_n <= a_on && next_a.neg;
      phase_b.out_p <= b_on && !next_b.neg && (next_b.mag != 8'h00);
      phase_b.out_n <= b_on && next_b.neg;
      phase_a.oe_n <= !(enable_n_low && standby_n);
      phase_b.oe_n <= !(enable_n_low && standby_n);
    end
  end

  // Open-drain monitor: enable low pulls the pin low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      home_position_flag_n_oe_n <= 1'b0;
    end else begin
      home_position_flag_n_oe_n <= (next_pos != mpsq_pkg::POS_INIT);
    end
  end

  assign home_position_flag_n_o = 1'b0;
endmodule

// [sim/mpsq_sequencer_asserts.sv]
`timescale 1ns/1ps
module mpsq_sequencer_asserts (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic step_clock, // Step
  input wire logic reset_n, // Home
  input wire logic enable_n_low, // Drive
  input wire logic standby_n, // Standby
  input wire logic step_mode_sel0, // Mode 0
  input wire logic step_mode_sel1, // Mode 1
  input wire logic sense_a_hit, // A trip
  input wire mpsq_pkg::mpsq_cur_t cur_a, // A cmd
  input wire mpsq_pkg::mpsq_cur_t cur_b, // B cmd
  input wire mpsq_pkg::mpsq_bridge_t phase_a, // A pins
  input wire mpsq_pkg::mpsq_bridge_t phase_b, // B pins
  input wire logic home_position_flag_n_o, // Mon data
  input wire logic home_position_flag_n_oe_n // Mon en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_reset_home: assert property (!reset_n |=> !home_position_flag_n_oe_n)
    else $error("no home on reset");
  chk_standby_float: assert property (!standby_n |=> phase_a.oe_n && phase_b.oe_n)
    else $error("standby drives");
  chk_en_float: assert property (!enable_n_low |=> phase_a.oe_n && phase_b.oe_n)
    else $error("disabled drives");
  chk_home_a: assert property (!home_position_flag_n_oe_n |-> cur_a == 9'h064)
    else $error("home A wrong");
  chk_home_b: assert property (!home_position_flag_n_oe_n &&
    $stable({step_mode_sel1, step_mode_sel0}) |->
    cur_b == ({step_mode_sel1, step_mode_sel0} == 2'h0 ? 9'h164 : 9'h000))
    else $error("home B wrong");
  chk_step_leave: assert property ($rose(step_clock) && reset_n && standby_n &&
    !home_position_flag_n_oe_n |-> ##[1:2] home_position_flag_n_oe_n)
    else $error("step missed");
  chk_release_high: assert property ($rose(reset_n) && standby_n && step_clock
    |-> ##[1:2] home_position_flag_n_oe_n) else $error("no instant step");
  chk_chop_trip: assert property ($rose(sense_a_hit) && enable_n_low && standby_n
    |-> ##[1:2] !(phase_a.out_p || phase_a.out_n)) else $error("no chop off");
  chk_od_data: assert property (home_position_flag_n_o == 1'b0)
    else $error("monitor data high");
endmodule
bind mpsq_sequencer mpsq_sequencer_asserts mpsq_sequencer_asserts_inst (.clk_sys, .rst_n,
  .step_clock, .reset_n, .enable_n_low, .standby_n, .step_mode_sel0, .step_mode_sel1,
  .sense_a_hit, .cur_a, .cur_b, .phase_a, .phase_b, .home_position_flag_n_o,
  .home_position_flag_n_oe_n);

// [sim/mpsq_host_model.sv]
`timescale 1ns/1ps
module mpsq_host_model (
  input wire logic clk_sys, // Clock
  input wire logic step_req, // One step per pulse
  output logic step_clock, // Step clock
  output logic chop_oscillator // Chop clock, 8 clk period
);
  logic [2:0] ph = 3'h0;
  logic [2:0] div = 3'h0;
  always_ff @(posedge clk_sys) begin
    if (step_req) ph <= 3'h4;
    else if (ph != 3'h0) ph <= ph - 3'h1;
  end
  // High two clocks then low, so no edge is ever merged
  assign step_clock = ph > 3'h2;
  always_ff @(posedge clk_sys) div <= div + 3'h1;
  assign chop_oscillator = div[2];
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, rst_n = 0, dir = 0, sel0 = 0, sel1 = 0, rs_n = 0, en = 1, sb = 1;
  logic sa = 0, sbh = 0, req = 0, stp, oscillator, flag, flag_oe_n;
  mpsq_pkg::mpsq_cur_t ca, cb;
  mpsq_pkg::mpsq_bridge_t pa, pb;
  int num_errors = 0, comparisons = 0;
  always #20 clk_sys = ~clk_sys;
  mpsq_host_model mpsq_host_model_inst (.clk_sys, .step_req(req), .step_clock(stp),
    .chop_oscillator(oscillator));
  mpsq_sequencer mpsq_sequencer_inst (.clk_sys, .rst_n, .step_clock(stp), .rotation_dir(dir),
    .step_mode_sel0(sel0), .step_mode_sel1(sel1), .reset_n(rs_n), .enable_n_low(en),
    .standby_n(sb), .chop_oscillator(oscillator), .sense_a_hit(sa), .sense_b_hit(sbh),
    .cur_a(ca), .cur_b(cb), .phase_a(pa), .phase_b(pb), .home_position_flag_n_o(flag),
    .home_position_flag_n_oe_n(flag_oe_n));
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) begin
      req = 1;
      tick(1);
      req = 0;
      tick(5);
    end
  endtask
  task home;
    rs_n = 0;
    tick(2);
    rs_n = 1;
    tick(2);
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      {sel1, sel0} = m[1:0];
      home();
      chk(ca, 9'h064);
      chk(cb, m == 0 ? 9'h164 : 9'h000);
      step(1);
      chk(ca, m == 0 ? 9'h064 : m == 1 ? 9'h047 : m == 2 ? 9'h05C : 9'h062);
      chk(cb, m == 0 ? 9'h064 : m == 1 ? 9'h047 : m == 2 ? 9'h026 : 9'h014);
      step((4 << m) - 2);
      chk(flag_oe_n, 1'h1);
      step(1);
      chk(flag_oe_n, 1'h0);
    end
    $display("modes done");
  endtask
  task t_dir;
    {sel1, sel0} = 2'h1;
    home();
    dir = 1;
    step(1);
    chk(flag_oe_n, 1'h1);
    chk(ca, 9'h047);
    chk(cb, 9'h147);
    dir = 0;
    step(1);
    chk(flag_oe_n, 1'h0);
    $display("direction done");
  endtask
  task t_enable;
    en = 0;
    tick(2);
    chk({pa.oe_n, pb.oe_n}, 2'h3);
    chk(flag_oe_n, 1'h0);
    step(3);
    en = 1;
    tick(2);
    chk(pa.oe_n, 1'h0);
    chk(flag_oe_n, 1'h1);
    chk(ca, 9'h147);
    chk(cb, 9'h047);
    step(5);
    chk(flag_oe_n, 1'h0);
    $display("enable done");
  endtask
  task t_reset;
    step(1);
    rs_n = 0;
    tick(2);
    chk(flag_oe_n, 1'h0);
    chk(flag, 1'h0);
    chk(ca, 9'h064);
    // Clock goes high while still in reset, so release meets a clock already high
    req = 1;
    tick(1);
    req = 0;
    tick(1);
    rs_n = 1;
    tick(3);
    chk(flag_oe_n, 1'h1);
    tick(4);
    home();
    tick(3);
    chk(flag_oe_n, 1'h0);
    step(1);
    chk(flag_oe_n, 1'h1);
    $display("reset done");
  endtask
  task t_standby;
    step(1);
    sb = 0;
    tick(2);
    chk({pa.oe_n, pb.oe_n}, 2'h3);
    chk(flag_oe_n, 1'h0);
    sb = 1;
    tick(2);
    chk({pa.oe_n, pb.oe_n}, 2'h0);
    chk(ca, 9'h064);
    chk(cb, 9'h000);
    $display("standby done");
  endtask
  task t_chop;
    int n;
    logic o;
    n = 0;
    step(1);
    chk({pa.out_p | pa.out_n, pb.out_p | pb.out_n}, 2'h3);
    // Trip mid low phase so no oscillator edge is ambiguous
    @(negedge oscillator);
    tick(2);
    sa = 1;
    sbh = 1;
    tick(2);
    chk({pa.out_p | pa.out_n, pb.out_p | pb.out_n}, 2'h0);
    sa = 0;
    sbh = 0;
    o = oscillator;
    for (int i = 0; i < 80 && !(pa.out_p | pa.out_n); i++) begin
      tick(1);
      n += (o && !oscillator);
      o = oscillator;
    end
    chk(n[8:0], {6'h00, mpsq_pkg::OFF_CYCLES});
    chk(pb.out_p | pb.out_n, 1'h1);
    $display("chop done");
  endtask
  task print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    tick(3);
    rst_n = 1;
    tick(1);
    t_modes();
    t_dir();
    t_enable();
    t_reset();
    t_standby();
    t_chop();
    print_verdict();
  end
endmodule
